// [bir_assertions.sv]
// Port checker for the board interrupt router, core clock domain.
// Assumes it is bound into bir_top; the link wire is judged by the bench.
`timescale 1ns/10ps
module bir_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       apic_mode,
  input wire logic [1:0] cpu_ack,
  input wire logic [3:0] smi_src,
  input wire logic       smi_gate_en,
  input wire logic       clr_smi,
  input wire logic       processor_legacy_irq,
  input wire logic [1:0] ack_grant,
  input wire logic [7:0] legacy_vector,
  input wire logic       legacy_vector_valid,
  input wire logic       sys_mgmt_irq_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////////
  // Causes: an acknowledge while the line is up, a gated error source
  sequence s_ack; $rose(cpu_ack[0]) && processor_legacy_irq && !apic_mode; endsequence
  sequence s_smi; $rose(|smi_src) && smi_gate_en && !clr_smi; endsequence
  property p_one_win; ack_grant != 2'b11; endproperty
  a_one_win: assert property (p_one_win) else $error("two grants");
  property p_pulse; ack_grant != 2'b00 |=> ack_grant == 2'b00; endproperty
  a_pulse: assert property (p_pulse) else $error("grant held");
  property p_pair; legacy_vector_valid == (ack_grant != 2'b00); endproperty
  a_pair: assert property (p_pair) else $error("valid without grant");
  property p_quiet; apic_mode |-> !processor_legacy_irq; endproperty
  a_quiet: assert property (p_quiet) else $error("legacy line in message mode");
  property p_ack; s_ack |-> ##[2:6] ack_grant != 2'b00; endproperty
  a_ack: assert property (p_ack) else $error("no grant after ack");
  // Cascade level never yields a vector of its own
  property p_vec;
    legacy_vector_valid |-> legacy_vector inside {[8'h08:8'h09], [8'h0b:8'h0f], [8'h70:8'h77]};
  endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_smi; s_smi |-> ##[2:6] !sys_mgmt_irq_n; endproperty
  a_smi: assert property (p_smi) else $error("error not raised");
  property p_gate; !smi_gate_en && !$past(smi_gate_en) |-> sys_mgmt_irq_n; endproperty
  a_gate: assert property (p_gate) else $error("error not gated");
endmodule
bind bir_top bir_chk u_chk (.*);

// [bir_legacy_pic.sv]
// One legacy eight-level interrupt controller: edge-caught requests, mask, in-service.
// Assumes requests are already synchronised to clk and ack/eoi are one-cycle pulses.
`timescale 1ns/10ps
module bir_legacy_pic #(
  parameter int WIDTH = bir_pkg::PIC_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] req,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic             ack,
  input  wire logic             eoi,
  output logic                  irq_out,
  output logic [2:0]            best_idx,
  output logic                  best_valid
);

  initial begin
    if (WIDTH != 8) begin
      $error("bir_legacy_pic supports eight levels only");
    end
  end

  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] irr_ff;
  logic [WIDTH-1:0] isr_ff;
  logic             irq_out_ff;
  logic [5:0]       cand_enc;
  logic [5:0]       isr_enc;
  logic             blocked;
  logic [WIDTH-1:0] ack_oh;
  logic [WIDTH-1:0] eoi_oh;

  //////////////////////////////////////////////////////////////////////////////
  // Priority resolution, level 0 highest
  assign cand_enc   = bir_pkg::first_set({24'h000000, irr_ff & ~mask});
  assign isr_enc    = bir_pkg::first_set({24'h000000, isr_ff});
  assign best_valid = cand_enc[5];
  assign best_idx   = cand_enc[2:0];
  // An equal or higher level in service holds off the request
  assign blocked    = isr_enc[5] && (isr_enc[2:0] <= cand_enc[2:0]);
  assign ack_oh     = (ack && best_valid) ? WIDTH'(1) << best_idx : '0;
  assign eoi_oh     = (eoi && isr_enc[5]) ? WIDTH'(1) << isr_enc[2:0] : '0;
  assign irq_out    = irq_out_ff;

  // Request latch; a new edge beats the acknowledge clear
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_ff <= '0;
      irr_ff  <= '0;
    end else begin
      prev_ff <= req;
      irr_ff  <= (irr_ff & ~ack_oh) | (req & ~prev_ff);
    end
  end

  // In-service bits, cleared highest first by end of interrupt
  always_ff @(posedge clk) begin
    if (srst) begin
      isr_ff <= '0;
    end else begin
      isr_ff <= (isr_ff | ack_oh) & ~eoi_oh;
    end
  end

  // Registered interrupt output
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_out_ff <= 1'b0;
    end else begin
      irq_out_ff <= best_valid && !blocked;
    end
  end

endmodule

// [bir_link_partner.sv]
// Local controllers on the two-lane link: decodes words, can jam one beat.
// Assumes lane changes on the rising link edge and pull-ups on both lanes.
`timescale 1ns/10ps
module bir_link_partner (
  input  wire logic        link_clk,
  input  wire logic [1:0]  oe_n,
  input  wire logic        jam,
  output logic      [1:0]  lanes,
  output logic      [15:0] word,
  output logic      [7:0]  cnt
);
  int   n = -2;
  logic pull = 1'b0;
  logic jammed = 1'b0;
  initial cnt = 8'h00;
  // Wired-and with pull-up, our own pull included
  assign lanes = oe_n & {2{~pull}};
  // Mid-beat sampling: idle, start, eight beats high pair first
  always @(negedge link_clk) begin
    pull <= 1'b0;
    if (!jam) jammed <= 1'b0;
    if (n == -2 && lanes == 2'b11) n <= -1;
    else if (n == -1 && lanes == 2'b00) n <= 0;
    else if (n >= 0) begin
      word <= {word[13:0], lanes};
      n <= (n == 7) ? -2 : n + 1;
      if (n == 7) cnt <= cnt + 8'h01;
      // One jam only, so the retry can land
      if (jam && !jammed && n == 2) begin
        pull <= 1'b1;
        jammed <= 1'b1;
        n <= -2;
      end
    end
  end
endmodule

// [bir_pkg.sv]
// Shared constants, state type and helper function for the board interrupt router.
// Assumes every user compiles this package first; nothing is imported, all uses are scoped.
package bir_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Request levels, inputs and mapping
  localparam int NUM_LEVELS       = 16;
  localparam int NUM_IOAPIC_IN    = 24;
  localparam int NUM_PCI          = 4;
  localparam int NUM_SLOTS        = 4;
  localparam int NUM_EXT          = 4;
  localparam int NUM_SMI_SRC      = 4;
  localparam int PIC_WIDTH        = 8;
  localparam int CASCADE_LEVEL    = 2;
  localparam int TIMER_LEVEL      = 0;
  localparam int TIMER_INPUT      = 2;
  localparam int LEGACY_IRQ_INPUT = 0;
  localparam int RTC_LEVEL        = 8;
  localparam int PCI_FIRST_INPUT  = 16;
  localparam int EXT_FIRST_INPUT  = 20;
  localparam int SCSI_PCI_LINE    = 0;
  localparam int NIC_PCI_LINE     = 1;

  //////////////////////////////////////////////////////////////////////////////
  // Vectors and message layout
  localparam int VEC_W                     = 8;
  localparam int IDX_W                     = 5;
  localparam int LVL_W                     = 4;
  localparam logic [VEC_W-1:0] PRI_VEC_BASE = 8'h08;
  localparam logic [VEC_W-1:0] SEC_VEC_BASE = 8'h70;
  localparam int MSG_W                     = 16;
  localparam int MSG_VEC_LSB               = 8;
  localparam int MSG_TRIG_POS              = 7;
  localparam int MSG_IDX_LSB               = 2;
  localparam int MSG_PAR_POS               = 1;
  localparam int LINK_LANES                = 2;
  localparam int MSG_BEATS                 = MSG_W / LINK_LANES;
  localparam logic [2:0] LAST_BEAT         = 3'(MSG_BEATS - 1);
  localparam logic [1:0] LINK_IDLE_BEATS   = 2'h2;

  // Link sender states, Gray along idle, start, shift, done
  typedef enum logic [1:0] {
    LNK_IDLE  = 2'b00,
    LNK_START = 2'b01,
    LNK_SHIFT = 2'b11,
    LNK_DONE  = 2'b10
  } bir_link_state_e;

  // Lowest set bit: {found, index}; lowest index is highest priority
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

endpackage

// [bir_top.sv]
// Board interrupt router: slot swizzle, rerouter, cascaded legacy pair, 24-input
// message controller with serial link sender, and management interrupt latch.
// Assumes asynchronous pins, a free-running link clock and static steering inputs.
`timescale 1ns/10ps
module bir_top #(
  parameter int NUM_IN = bir_pkg::NUM_IOAPIC_IN
) (
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  input  wire logic                          link_clk,
  input  wire logic                          apic_mode,
  input  wire logic [15:0]                   isa_irq,
  input  wire logic                          rtc_request_n,
  input  wire logic [15:0]                   slot_irq_n,
  input  wire logic                          scsi_irq_n,
  input  wire logic                          nic_irq_n,
  input  wire logic [3:0]                    ext_irq,
  input  wire logic [3:0]                    sb_steer_en,
  input  wire logic [15:0]                   sb_steer_level,
  input  wire logic [3:0]                    rr_en,
  input  wire logic [15:0]                   rr_level,
  input  wire logic [15:0]                   pic_mask,
  input  wire logic [1:0]                    cpu_ack,
  input  wire logic                          pic_eoi_pri,
  input  wire logic                          pic_eoi_sec,
  output logic                               processor_legacy_irq,
  output logic [1:0]                         ack_grant,
  output logic [7:0]                         legacy_vector,
  output logic                               legacy_vector_valid,
  input  wire logic [NUM_IN*8-1:0]           redir_vector,
  input  wire logic [NUM_IN-1:0]             redir_mask,
  input  wire logic [NUM_IN-1:0]             redir_level,
  input  wire logic                          ioapic_eoi,
  input  wire logic [4:0]                    ioapic_eoi_index,
  input  wire logic [1:0]                    apic_data_in,
  output logic [1:0]                         apic_data_out,
  output logic [1:0]                         apic_data_oe_n,
  input  wire logic [3:0]                    smi_src,
  input  wire logic                          smi_gate_en,
  input  wire logic                          clr_smi,
  output logic                               sys_mgmt_irq_n
);

  initial begin
    if (NUM_IN != bir_pkg::NUM_IOAPIC_IN) begin
      $error("bir_top: the input map is fixed at 24 message inputs");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every asynchronous pin
  localparam int SYNC_W = 16 + 1 + 16 + 1 + 1 + 4 + 2 + 1 + 1 + 4 + 1;
  // Active-low pins idle high, so reset leaves no false edge
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {16'h0000, 1'b1, 16'hffff, 2'h3, 4'h0, 2'h0,
                                             2'h0, 4'h0, 1'b0};
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] pins_raw;

  assign pins_raw = {isa_irq, rtc_request_n, slot_irq_n, scsi_irq_n, nic_irq_n, ext_irq,
                     cpu_ack, pic_eoi_pri, pic_eoi_sec, smi_src, clr_smi};

  // First stage is read only by the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic [15:0] isa_s;
  logic        rtc_n_s;
  logic [15:0] slot_n_s;
  logic        scsi_n_s;
  logic        nic_n_s;
  logic [3:0]  ext_s;
  logic [1:0]  ack_s;
  logic        eoi_pri_s;
  logic        eoi_sec_s;
  logic [3:0]  smi_s;
  logic        clr_smi_s;

  assign {isa_s, rtc_n_s, slot_n_s, scsi_n_s, nic_n_s, ext_s,
          ack_s, eoi_pri_s, eoi_sec_s, smi_s, clr_smi_s} = sync2_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Slot swizzle: slot s pin p lands on line (p + s) mod 4
  logic [3:0] pci_line_n;
  logic       pci_irq_line_a_n;
  logic       pci_irq_line_b_n;
  logic       pci_irq_line_c_n;
  logic       pci_irq_line_d_n;
  logic [3:0] pci_act;

  // Wired-AND of active-low sources; rotation keeps every slot's pin A apart
  always_comb begin
    pci_line_n = 4'hf;
    for (int s = 0; s < bir_pkg::NUM_SLOTS; s++) begin
      for (int p = 0; p < bir_pkg::NUM_PCI; p++) begin
        pci_line_n[(p + s) % 4] = pci_line_n[(p + s) % 4] & slot_n_s[s*4+p];
      end
    end
    pci_line_n[bir_pkg::SCSI_PCI_LINE] = pci_line_n[bir_pkg::SCSI_PCI_LINE] & scsi_n_s;
    pci_line_n[bir_pkg::NIC_PCI_LINE]  = pci_line_n[bir_pkg::NIC_PCI_LINE] & nic_n_s;
  end

  assign pci_irq_line_a_n = pci_line_n[0];
  assign pci_irq_line_b_n = pci_line_n[1];
  assign pci_irq_line_c_n = pci_line_n[2];
  assign pci_irq_line_d_n = pci_line_n[3];
  assign pci_act = ~{pci_irq_line_d_n, pci_irq_line_c_n, pci_irq_line_b_n, pci_irq_line_a_n};

  //////////////////////////////////////////////////////////////////////////////
  // Rerouter and internal steering onto legacy levels
  logic [15:0] rr_hit;
  logic [15:0] sb_hit;
  logic [15:0] lvl_apic;
  logic [15:0] lvl_pic;

  // Level 0 selects nothing; the rerouter also feeds the message path
  always_comb begin
    rr_hit = 16'h0000;
    sb_hit = 16'h0000;
    for (int i = 0; i < bir_pkg::NUM_PCI; i++) begin
      if (rr_en[i] && pci_act[i] && rr_level[i*4 +: 4] != 4'h0) begin
        rr_hit[rr_level[i*4 +: 4]] = 1'b1;
      end
      if (sb_steer_en[i] && pci_act[i] && sb_steer_level[i*4 +: 4] != 4'h0) begin
        sb_hit[sb_steer_level[i*4 +: 4]] = 1'b1;
      end
    end
  end

  // Level 2 carries only the cascade; a steer to 2 is dropped
  always_comb begin
    lvl_apic = isa_s | rr_hit;
    lvl_apic[bir_pkg::RTC_LEVEL] = lvl_apic[bir_pkg::RTC_LEVEL] | ~rtc_n_s;
    lvl_apic[bir_pkg::CASCADE_LEVEL] = 1'b0;
    lvl_pic = lvl_apic | sb_hit;
    lvl_pic[bir_pkg::CASCADE_LEVEL] = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cascaded legacy pair and processor acknowledge
  logic       pri_irq;
  logic       sec_irq;
  logic [2:0] pri_best;
  logic [2:0] sec_best;
  logic       pri_valid;
  logic       sec_valid;
  logic [1:0] ack_prev_ff;
  logic [1:0] ack_p;
  logic       eoi_prev_pri_ff;
  logic       eoi_prev_sec_ff;
  logic       pri_ack;
  logic       sec_ack;
  logic [7:0] pri_req;

  assign ack_p   = ack_s & ~ack_prev_ff;
  assign pri_ack = !apic_mode && processor_legacy_irq && (|ack_p);
  assign sec_ack = pri_ack && pri_best == 3'(bir_pkg::CASCADE_LEVEL);
  // Secondary output enters primary level 2
  always_comb begin
    pri_req = lvl_pic[7:0];
    pri_req[bir_pkg::CASCADE_LEVEL] = sec_irq;
  end

  bir_legacy_pic #(.WIDTH(bir_pkg::PIC_WIDTH)) u_pic_pri (
    .clk        (core_clk),
    .srst       (srst),
    .req        (pri_req),
    .mask       (pic_mask[7:0]),
    .ack        (pri_ack),
    .eoi        (eoi_pri_s && !eoi_prev_pri_ff),
    .irq_out    (pri_irq),
    .best_idx   (pri_best),
    .best_valid (pri_valid)
  );

  bir_legacy_pic #(.WIDTH(bir_pkg::PIC_WIDTH)) u_pic_sec (
    .clk        (core_clk),
    .srst       (srst),
    .req        (lvl_pic[15:8]),
    .mask       (pic_mask[15:8]),
    .ack        (sec_ack),
    .eoi        (eoi_sec_s && !eoi_prev_sec_ff),
    .irq_out    (sec_irq),
    .best_idx   (sec_best),
    .best_valid (sec_valid)
  );

  // One shared line to every processor, silent in message mode
  assign processor_legacy_irq = pri_irq && !apic_mode;

  logic [1:0] ack_grant_ff;
  logic [7:0] legacy_vector_ff;
  logic       legacy_vector_valid_ff;

  // Processor 0 wins a same-cycle acknowledge, so one answer only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_prev_ff            <= 2'h0;
      eoi_prev_pri_ff        <= 1'b0;
      eoi_prev_sec_ff        <= 1'b0;
      ack_grant_ff           <= 2'h0;
      legacy_vector_ff       <= 8'h00;
      legacy_vector_valid_ff <= 1'b0;
    end else begin
      ack_prev_ff            <= ack_s;
      eoi_prev_pri_ff        <= eoi_pri_s;
      eoi_prev_sec_ff        <= eoi_sec_s;
      legacy_vector_valid_ff <= pri_ack && pri_valid;
      ack_grant_ff           <= 2'h0;
      if (pri_ack) begin
        ack_grant_ff <= ack_p[0] ? 2'h1 : 2'h2;
        legacy_vector_ff <= sec_ack ? bir_pkg::SEC_VEC_BASE + 8'(sec_best)
                                    : bir_pkg::PRI_VEC_BASE + 8'(pri_best);
      end
    end
  end

  assign ack_grant           = ack_grant_ff;
  assign legacy_vector       = legacy_vector_ff;
  assign legacy_vector_valid = legacy_vector_valid_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Message controller inputs and pending state
  logic [NUM_IN-1:0] io_in;
  logic [NUM_IN-1:0] io_prev_ff;
  logic [NUM_IN-1:0] pend_ff;
  logic [NUM_IN-1:0] rirr_ff;
  logic [NUM_IN-1:0] set_ev;
  logic [NUM_IN-1:0] disp_oh;
  logic [NUM_IN-1:0] eoi_oh;
  logic [5:0]        pick;
  logic              busy_ff;
  logic              dispatch;
  logic              done_p;

  // Fixed input map; keyboard stays on 1, level 2 has no input of its own
  always_comb begin
    io_in = '0;
    io_in[15:3] = lvl_apic[15:3];
    io_in[1] = lvl_apic[1];
    io_in[bir_pkg::TIMER_INPUT] = lvl_apic[bir_pkg::TIMER_LEVEL];
    io_in[bir_pkg::LEGACY_IRQ_INPUT] = pri_irq;
    io_in[bir_pkg::PCI_FIRST_INPUT +: 4] = pci_act & ~rr_en;
    io_in[bir_pkg::EXT_FIRST_INPUT +: 4] = ext_s;
  end

  assign pick     = bir_pkg::first_set(32'(pend_ff & ~redir_mask));
  assign dispatch = apic_mode && !busy_ff && pick[5];
  assign disp_oh  = dispatch ? NUM_IN'(1) << pick[4:0] : '0;
  assign eoi_oh   = ioapic_eoi ? NUM_IN'(1) << ioapic_eoi_index : '0;
  // Edge entries catch rising edges; level entries re-arm after end of interrupt
  assign set_ev   = (io_in & ~io_prev_ff & ~redir_level)
                  | (io_in & redir_level & ~rirr_ff & ~disp_oh);

  // A fresh edge in the dispatch cycle stays pending
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_prev_ff <= '0;
      pend_ff    <= '0;
      rirr_ff    <= '0;
    end else begin
      io_prev_ff <= io_in;
      pend_ff    <= (pend_ff & ~disp_oh) | set_ev;
      rirr_ff    <= (rirr_ff & ~eoi_oh) | (disp_oh & redir_level);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Message build and toggle handshake toward the link domain
  logic [bir_pkg::MSG_W-1:0] msg_ff;
  logic [bir_pkg::VEC_W-1:0] vec_sel;
  logic                      req_tgl_ff;
  logic                      ack_s1_ff;
  logic                      ack_s2_ff;
  logic                      ack_seen_ff;
  logic                      lnk_ack_tgl_ff;

  assign vec_sel = redir_vector[pick[4:0]*8 +: 8];
  assign done_p  = ack_s2_ff != ack_seen_ff;

  // Word stays still while a request is outstanding
  always_ff @(posedge core_clk) begin
    if (srst) begin
      msg_ff     <= '0;
      req_tgl_ff <= 1'b0;
      busy_ff    <= 1'b0;
    end else if (dispatch) begin
      msg_ff[bir_pkg::MSG_VEC_LSB +: 8]              <= vec_sel;
      msg_ff[bir_pkg::MSG_TRIG_POS]                  <= redir_level[pick[4:0]];
      msg_ff[bir_pkg::MSG_IDX_LSB +: bir_pkg::IDX_W] <= pick[4:0];
      msg_ff[bir_pkg::MSG_PAR_POS]   <= ^{vec_sel, redir_level[pick[4:0]], pick[4:0]};
      msg_ff[0]                      <= 1'b0;
      req_tgl_ff                     <= ~req_tgl_ff;
      busy_ff                        <= 1'b1;
    end else if (done_p) begin
      busy_ff <= 1'b0;
    end
  end

  // Completion toggle back from the link
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_s1_ff   <= 1'b0;
      ack_s2_ff   <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else begin
      ack_s1_ff   <= lnk_ack_tgl_ff;
      ack_s2_ff   <= ack_s1_ff;
      ack_seen_ff <= ack_s2_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: serial sender, two bits per beat, open-drain
  bir_pkg::bir_link_state_e  lnk_state_ff;
  logic                      lnk_rst_s1_ff;
  logic                      lnk_rst_ff;
  logic                      lnk_req_s1_ff;
  logic                      lnk_req_s2_ff;
  logic [1:0]                lnk_idle_ff;
  logic [2:0]                lnk_beat_ff;
  logic [1:0]                lnk_drive_ff;
  logic [bir_pkg::MSG_W-1:0] lnk_sh_ff;
  logic                      lnk_lost;

  // Reset and request toggle cross on two flops
  always_ff @(posedge link_clk) begin
    lnk_rst_s1_ff <= srst;
    lnk_rst_ff    <= lnk_rst_s1_ff;
    lnk_req_s1_ff <= req_tgl_ff;
    lnk_req_s2_ff <= lnk_req_s1_ff;
  end

  // Released lane seen low means another sender holds the bus
  assign lnk_lost = |(lnk_drive_ff & ~apic_data_in);

  // Bus idle count: both lanes high for consecutive beats
  always_ff @(posedge link_clk) begin
    if (lnk_rst_ff) begin
      lnk_idle_ff <= 2'h0;
    end else if (apic_data_in != 2'h3) begin
      lnk_idle_ff <= 2'h0;
    end else if (lnk_idle_ff != bir_pkg::LINK_IDLE_BEATS) begin
      lnk_idle_ff <= lnk_idle_ff + 2'h1;
    end
  end

  // Sender; loss of arbitration returns to idle and retries the same word
  always_ff @(posedge link_clk) begin
    if (lnk_rst_ff) begin
      lnk_state_ff   <= bir_pkg::LNK_IDLE;
      lnk_ack_tgl_ff <= 1'b0;
      lnk_beat_ff    <= 3'h0;
      lnk_drive_ff   <= 2'h3;
      lnk_sh_ff      <= '0;
    end else begin
      unique case (lnk_state_ff)
        bir_pkg::LNK_IDLE: begin
          lnk_drive_ff <= 2'h3;
          if (lnk_req_s2_ff != lnk_ack_tgl_ff && lnk_idle_ff == bir_pkg::LINK_IDLE_BEATS) begin
            lnk_sh_ff    <= msg_ff;
            lnk_drive_ff <= 2'h0;
            lnk_state_ff <= bir_pkg::LNK_START;
          end
        end
        bir_pkg::LNK_START: begin
          lnk_drive_ff <= lnk_sh_ff[bir_pkg::MSG_W-1 -: 2];
          lnk_sh_ff    <= lnk_sh_ff << 2;
          lnk_beat_ff  <= 3'h0;
          lnk_state_ff <= bir_pkg::LNK_SHIFT;
        end
        bir_pkg::LNK_SHIFT: begin
          if (lnk_lost) begin
            lnk_drive_ff <= 2'h3;
            lnk_state_ff <= bir_pkg::LNK_IDLE;
          end else if (lnk_beat_ff == bir_pkg::LAST_BEAT) begin
            lnk_drive_ff <= 2'h3;
            lnk_state_ff <= bir_pkg::LNK_DONE;
          end else begin
            lnk_drive_ff <= lnk_sh_ff[bir_pkg::MSG_W-1 -: 2];
            lnk_sh_ff    <= lnk_sh_ff << 2;
            lnk_beat_ff  <= lnk_beat_ff + 3'h1;
          end
        end
        bir_pkg::LNK_DONE: begin
          lnk_ack_tgl_ff <= ~lnk_ack_tgl_ff;
          lnk_state_ff   <= bir_pkg::LNK_IDLE;
        end
      endcase
    end
  end

  // Open drain: pull low by enabling, release for a one
  assign apic_data_out  = 2'h0;
  assign apic_data_oe_n = lnk_drive_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Management interrupt: merged sources, latched, cleared, gated
  logic smi_lat_ff;
  logic sys_mgmt_irq_n_ff;

  // A new error in the clear cycle keeps the latch set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      smi_lat_ff        <= 1'b0;
      sys_mgmt_irq_n_ff <= 1'b1;
    end else begin
      smi_lat_ff        <= (smi_lat_ff && !clr_smi_s) || (|smi_s);
      sys_mgmt_irq_n_ff <= !(smi_lat_ff && smi_gate_en);
    end
  end

  assign sys_mgmt_irq_n = sys_mgmt_irq_n_ff;

endmodule

// [testbench.sv]
// Self-checking bench for the board interrupt router with a link partner.
// Assumes the package, design, checker and partner are compiled first.
`timescale 1ns/10ps
module testbench;
  logic         core_clk, link_clk, srst, apic_mode, rtc_request_n, scsi_irq_n, nic_irq_n;
  logic         pic_eoi_pri, pic_eoi_sec, ioapic_eoi, smi_gate_en, clr_smi, jam;
  logic         processor_legacy_irq, legacy_vector_valid, sys_mgmt_irq_n;
  logic [1:0]   cpu_ack, ack_grant, apic_data_in, apic_data_out, apic_data_oe_n;
  logic [3:0]   ext_irq, sb_steer_en, rr_en, smi_src;
  logic [4:0]   ioapic_eoi_index;
  logic [7:0]   legacy_vector, cnt;
  logic [15:0]  isa_irq, slot_irq_n, sb_steer_level, rr_level, pic_mask, word;
  logic [23:0]  redir_mask, redir_level;
  logic [191:0] redir_vector;
  int           n_fail = 0, total_checks = 0, cyc = 0;
  bir_top dut (.*);
  bir_link_partner lp (.link_clk(link_clk), .oe_n(apic_data_oe_n), .jam(jam),
    .lanes(apic_data_in), .word(word), .cnt(cnt));
  //////////////////////////////////////////////////////////////////////////////
  // Clocks of unrelated phase; link stands for the far side's own clock
  initial begin core_clk = 0; forever #50 core_clk = ~core_clk; end
  initial begin link_clk = 0; #17; forever #32 link_clk = ~link_clk; end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin n_fail++; end_sim(); end
  end
  task automatic tick(input int k); repeat (k) @(negedge core_clk); endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Source below 16 is a level, 32 up a slot pin; expect word for that input
  task automatic t_msg(input int src, input int idx);
    logic [7:0] c0;
    logic [13:0] h;
    c0 = cnt;
    h = {8'(8'h40 + idx), redir_level[idx], 5'(idx)};
    if (src < 16) isa_irq[src] = 1'b1; else if (src < 32) ext_irq[src-16] = 1'b1;
    else slot_irq_n[src-32] = 1'b0;
    for (int i = 0; i < 200 && cnt == c0; i++) @(negedge core_clk);
    chk(word, {h, ^h, 1'b0});
    chk({8'h00, cnt}, {8'h00, 8'(c0 + 8'h01)});
    isa_irq = '0; ext_irq = '0; slot_irq_n = '1; tick(20);
    $display("message input %0d done", idx);
  endtask
  // Raise a level, acknowledge, then close it with end of interrupt
  task automatic t_legacy(input int lvl, input logic [1:0] acks, input logic [7:0] vec);
    if (lvl < 16) isa_irq[lvl] = 1'b1; else slot_irq_n[lvl-16] = 1'b0;
    for (int i = 0; i < 20 && !processor_legacy_irq; i++) @(negedge core_clk);
    cpu_ack = acks;
    for (int i = 0; i < 20 && !legacy_vector_valid; i++) @(negedge core_clk);
    chk({8'h00, legacy_vector}, {8'h00, vec});
    chk({14'h0000, ack_grant}, {14'h0000, acks[0] ? 2'b01 : 2'b10});
    cpu_ack = 2'b00; isa_irq = '0; slot_irq_n = '1; pic_eoi_pri = 1'b1; pic_eoi_sec = lvl > 7;
    tick(4); pic_eoi_pri = 1'b0; pic_eoi_sec = 1'b0; tick(4);
    $display("legacy level %0d done", lvl);
  endtask
  // Error latch raised, or held off by the gate, then cleared
  task automatic t_smi(input logic gate);
    smi_gate_en = gate; smi_src[2] = 1'b1; tick(8);
    chk({15'h0000, sys_mgmt_irq_n}, {15'h0000, !gate});
    smi_src = '0; clr_smi = 1'b1; tick(2); clr_smi = 1'b0; tick(2);
    chk({15'h0000, sys_mgmt_irq_n}, 16'h0001);
    $display("error gate %0d done", gate);
  endtask
  initial begin
    srst = 1; apic_mode = 1; jam = 0; {rtc_request_n, scsi_irq_n, nic_irq_n} = 3'h7;
    {pic_eoi_pri, pic_eoi_sec, ioapic_eoi, smi_gate_en, clr_smi, cpu_ack} = '0;
    {ioapic_eoi_index, isa_irq, ext_irq, smi_src, sb_steer_en, sb_steer_level} = '0;
    redir_level = '0; slot_irq_n = '1; rr_en = 4'h2; rr_level = 16'h0050;
    sb_steer_en = 4'h4; sb_steer_level = 16'h0600;
    pic_mask = 16'hffff; redir_mask = 24'h000001;
    for (int i = 0; i < 24; i++) redir_vector[i*8+:8] = 8'(8'h40 + i);
    tick(2); srst = 0; tick(4);
    chk({14'h0000, apic_data_oe_n}, 16'h0003);
    chk({14'h0000, apic_data_out}, 16'h0000);
    chk({14'h0000, processor_legacy_irq, sys_mgmt_irq_n}, 16'h0001);
    t_msg(0, 2);
    t_msg(1, 1);
    t_msg(9, 9);
    t_msg(37, 18);
    jam = 1; t_msg(16, 20); jam = 0;
    redir_level[21] = 1'b1; t_msg(17, 21);
    // Second reset flushes legacy requests caught in message mode
    apic_mode = 0; srst = 1; tick(2); srst = 0; pic_mask = '0; tick(4);
    t_legacy(3, 2'b01, 8'h0b);
    t_legacy(10, 2'b11, 8'h72);
    t_legacy(20, 2'b01, 8'h0d);
    t_legacy(21, 2'b10, 8'h0e);
    t_smi(1'b1);
    t_smi(1'b0);
    end_sim();
  end
endmodule
